// ==== include/lbc_pkg.sv ====
// Constants, encodings and types for the local bus control block
package lbc_pkg;
  // Bus status codes
  localparam logic [2:0] ST_INT_ACK_STROBE_N = 3'h0; // [R2]
  localparam logic [2:0] ST_IORD = 3'h1;
  localparam logic [2:0] ST_IOWR = 3'h2;
  localparam logic [2:0] ST_HALT = 3'h3;
  localparam logic [2:0] ST_CODE = 3'h4; // [R1]
  localparam logic [2:0] ST_MRD = 3'h5;
  localparam logic [2:0] ST_MWR = 3'h6;
  localparam logic [2:0] ST_PASSIVE = 3'h7;
  // Reset values
  localparam logic [2:0] RST_STATUS = 3'h7;
  localparam logic [1:0] RST_QUEUE = 2'h0;
  // Request/grant pulse width in clocks
  localparam int RG_PULSE_CYCLES = 1;
  // Bus state machine
  typedef enum logic [2:0] {
    T_IDLE = 3'h0,
    T_1 = 3'h1,
    T_2 = 3'h2,
    T_3 = 3'h3,
    T_W = 3'h4,
    T_4 = 3'h5,
    T_HOLD = 3'h6
  } tstate_e;
  // Handover sequencer
  typedef enum logic [2:0] {
    RG_IDLE = 3'h0,
    RG_WAIT = 3'h1,
    RG_GRANT = 3'h2,
    RG_OWNED = 3'h3,
    RG_DEAD = 3'h4
  } rg_e;
endpackage

// ==== design/sync2.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ==== design/rq_grant.sv ====
// Pulse-based request/grant handover on two prioritised lines
`timescale 1ns/1ps
module rq_grant (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Synchronised line levels, low is a pulse
  input wire logic line_hi_in,
  input wire logic line_lo_in,
  // Bus state from the sequencer
  input wire logic at_boundary,
  input wire logic enable,
  // Line drive, one-cycle low pulse while oe is high
  output logic line_hi_out,
  output logic line_hi_oe,
  output logic line_lo_out,
  output logic line_lo_oe,
  // Floating request and ownership state
  output logic want_release,
  output logic released
);
  lbc_pkg::rg_e st;
  lbc_pkg::rg_e next_st;
  logic who;
  logic next_who;
  logic req_hi;
  logic req_lo;
  logic end_pulse;
  logic pend_hi;
  logic pend_lo;
  logic want_hi;
  logic want_lo;
  logic take_hi;
  logic take_lo;
  logic own_hi;
  logic own_lo;
  logic echo_gone;
  logic grant_now;
  logic [1:0] own_cnt;
  assign req_hi = ~line_hi_in;
  assign req_lo = ~line_lo_in;
  // Our own grant pulse comes back through the synchroniser early in the tenure; it must not end it
  assign echo_gone = (own_cnt == 2'h3);
  assign end_pulse = echo_gone && (who ? req_lo : req_hi);
  assign own_hi = (st == lbc_pkg::RG_OWNED) && !who;
  assign own_lo = (st == lbc_pkg::RG_OWNED) && who;
  assign want_hi = enable && (req_hi || pend_hi);
  assign want_lo = enable && (req_lo || pend_lo);
  assign take_hi = (st == lbc_pkg::RG_IDLE) && want_hi;
  assign take_lo = (st == lbc_pkg::RG_IDLE) && !want_hi && want_lo;
  assign grant_now = (next_st == lbc_pkg::RG_GRANT) && (st != lbc_pkg::RG_GRANT);
  assign want_release = (st == lbc_pkg::RG_WAIT);
  assign released = (st == lbc_pkg::RG_GRANT) || (st == lbc_pkg::RG_OWNED);
  always_comb begin
    next_st = st;
    next_who = who;
    case (st)
      lbc_pkg::RG_IDLE: begin
        if (take_hi) begin // [R5]
          next_st = lbc_pkg::RG_WAIT;
          next_who = 1'b0;
        end else if (take_lo) begin
          next_st = lbc_pkg::RG_WAIT;
          next_who = 1'b1;
        end
      end
      lbc_pkg::RG_WAIT: if (at_boundary) next_st = lbc_pkg::RG_GRANT; // [R4] [R7]
      lbc_pkg::RG_GRANT: next_st = lbc_pkg::RG_OWNED;
      lbc_pkg::RG_OWNED: if (end_pulse) next_st = lbc_pkg::RG_DEAD; // [R8]
      lbc_pkg::RG_DEAD: next_st = lbc_pkg::RG_IDLE; // [R9]
      default: next_st = lbc_pkg::RG_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= lbc_pkg::RG_IDLE;
      who <= 1'b0;
    end else begin
      st <= next_st;
      who <= next_who;
    end
  end
  // Grant pulse is driven exactly for the cycle after entering GRANT
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      line_hi_out <= 1'b1;
      line_hi_oe <= 1'b0;
      line_lo_out <= 1'b1;
      line_lo_oe <= 1'b0;
    end else begin
      line_hi_oe <= grant_now && !next_who; // [R7]
      line_hi_out <= !(grant_now && !next_who);
      line_lo_oe <= grant_now && next_who;
      line_lo_out <= !(grant_now && next_who);
    end
  end
  // A pulse that loses to the other line or arrives while busy is kept until served
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pend_hi <= 1'b0;
      pend_lo <= 1'b0;
      own_cnt <= 2'h0;
    end else begin
      pend_hi <= enable && !take_hi && (pend_hi || (req_hi && !own_hi)); // [R5]
      pend_lo <= enable && !take_lo && (pend_lo || (req_lo && !own_lo)); // [R5]
      own_cnt <= (st != lbc_pkg::RG_OWNED) ? 2'h0 : (echo_gone ? own_cnt : own_cnt + 2'h1); // [R8]
    end
  end
endmodule

// ==== design/cpu_local_bus_control.sv ====
// Local bus control and bus-mastership logic for min and max mode
// Contract
// R1: Status 100 code fetch, 101 memory read, 110 memory write, 111 passive.
// R2: Status 000 interrupt ack, 001 I/O read, 010 I/O write, 011 halt.
// R3: Status leaves passive in T4 before a cycle, returns in T3 or ready TW; code leaves passive in T1 and always returns in T3.
// R4: Bus released to another master only at end of current cycle.
// R5: Request on high-priority line wins over low-priority line.
// R6: Requester signals with a single one-clock low pulse.
// R7: Grant pulse one clock in T4 or T1, hold state on next clock; code enters hold first and pulses the grant pin in the second hold clock.
// R8: Third pulse ends tenure; device may reclaim bus next clock.
// R9: Three pulses per exchange, one idle clock between exchanges.
// R10: Lock low from lock prefix until next instruction completes, float in hold.
// R11: Queue status shown the cycle after the queue operation.
// R12: Memory/IO select valid T4 before cycle to final T4, float in hold; code drives it valid from T1.
// R13: Write strobe low in T2, T3, T4 of writes, float in hold.
// R14: Interrupt-ack strobe low in T2, T3, T4 of acknowledge cycles.
// R15: Address latch pulse high in T1, never floated.
// R16: Transceiver direction high transmit, timed like memory/IO, float in hold.
// R17: Transceiver enable low T2 to T4 for reads, acks and writes; code enables reads and acks only from T3.
// R18: Hold request seen high gives hold grant at T4 or T1, bus floats.
// R19: Hold request low drops hold grant; drive bus again on next cycle.
// R20: Hold request must be synchronous to the processor clock.
// R21: Mode strap selects minimum or maximum mode functions.
// R22: Shared pins carry max-mode or min-mode functions per strap.
// R23: Control outputs stay driven and inactive between cycles while owning bus.
`timescale 1ns/1ps
module cpu_local_bus_control (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Mode strap, high selects minimum mode
  input wire logic min_mode_strap,
  // Core side: cycle request, type code, ready
  input wire logic cyc_req,
  input wire logic [2:0] cyc_type,
  input wire logic ready,
  input wire logic lock_prefix,
  input wire logic instr_done,
  input wire logic [1:0] queue_op,
  // Core side answers
  output logic cyc_busy,
  output logic cyc_done,
  // Max mode status and lock
  output logic [2:0] bus_status,
  output logic bus_status_oe,
  output logic lock_n,
  output logic lock_oe,
  output logic queue_state_bit1,
  output logic queue_state_bit0,
  // Max mode request/grant lines as in, out, enable
  input wire logic bus_req_grant_hi_pri_in,
  output logic bus_req_grant_hi_pri_out,
  output logic bus_req_grant_hi_pri_oe,
  input wire logic bus_req_grant_lo_pri_in,
  output logic bus_req_grant_lo_pri_out,
  output logic bus_req_grant_lo_pri_oe,
  // Min mode controls
  output logic mem_io_sel,
  output logic write_n,
  output logic int_ack_strobe_n,
  output logic addr_latch,
  output logic xcvr_direction,
  output logic xcvr_enable_n,
  output logic ctrl_oe,
  input wire logic hold_req,
  output logic hold_grant
);
  lbc_pkg::tstate_e ts;
  lbc_pkg::tstate_e next_ts;
  logic [2:0] cur_type;
  logic strap_q;
  logic min_mode;
  logic rg_hi_s;
  logic rg_lo_s;
  logic [1:0] rg_pins_s;
  logic want_rel;
  logic rg_released;
  logic boundary;
  logic lock_act;
  logic hold_q;
  logic hold_state;
  logic rg_hi_out;
  logic rg_hi_oe;
  logic rg_lo_out;
  logic rg_lo_oe;

  // Pin inputs pass two flip-flops
  sync2 #(.WIDTH(2), .INIT(2'h3)) u_rg_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d({bus_req_grant_hi_pri_in, bus_req_grant_lo_pri_in}),
    .q(rg_pins_s)
  );
  assign rg_hi_s = rg_pins_s[1];
  assign rg_lo_s = rg_pins_s[0];
  sync2 #(.WIDTH(1), .INIT(1'b0)) u_strap_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d(min_mode_strap),
    .q(strap_q)
  );
  // The hold input gets the same two stages; the partner keeps it synchronous anyway [R20]
  sync2 #(.WIDTH(1), .INIT(1'b0)) u_hold_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d(hold_req),
    .q(hold_q)
  );
  assign min_mode = strap_q; // [R21]

  // Boundary is T4 of a finishing cycle or an idle T1 slot
  assign boundary = (ts == lbc_pkg::T_4) || (ts == lbc_pkg::T_IDLE);

  rq_grant u_rg (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .line_hi_in(rg_hi_s),
    .line_lo_in(rg_lo_s),
    .at_boundary(boundary && !lock_act), // [R4]
    .enable(!min_mode), // [R22]
    .line_hi_out(rg_hi_out),
    .line_hi_oe(rg_hi_oe),
    .line_lo_out(rg_lo_out),
    .line_lo_oe(rg_lo_oe),
    .want_release(want_rel),
    .released(rg_released)
  );

  // Hold state comes from either handover scheme
  wire hold_ask = min_mode ? hold_q : (want_rel || rg_released);
  // Grant and hold entry share one edge, so no cycle can start on a bus already granted away
  wire go_hold = boundary && (min_mode ? hold_q : (want_rel && !lock_act)); // [R18] [R7] [R4]
  wire leave_hold = !hold_ask; // [R19] [R8]

  always_comb begin
    next_ts = ts;
    case (ts)
      lbc_pkg::T_IDLE: begin
        if (go_hold) next_ts = lbc_pkg::T_HOLD;
        else if (cyc_req) next_ts = lbc_pkg::T_1;
      end
      lbc_pkg::T_1: next_ts = lbc_pkg::T_2;
      lbc_pkg::T_2: next_ts = lbc_pkg::T_3;
      lbc_pkg::T_3: next_ts = ready ? lbc_pkg::T_4 : lbc_pkg::T_W;
      lbc_pkg::T_W: next_ts = ready ? lbc_pkg::T_4 : lbc_pkg::T_W;
      lbc_pkg::T_4: begin
        if (go_hold) next_ts = lbc_pkg::T_HOLD; // [R4]
        else if (cyc_req) next_ts = lbc_pkg::T_1;
        else next_ts = lbc_pkg::T_IDLE;
      end
      lbc_pkg::T_HOLD: if (leave_hold) next_ts = lbc_pkg::T_IDLE;
      default: next_ts = lbc_pkg::T_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) ts <= lbc_pkg::T_IDLE;
    else ts <= next_ts;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) cur_type <= lbc_pkg::ST_PASSIVE;
    else if (next_ts == lbc_pkg::T_1 && ts != lbc_pkg::T_1) cur_type <= cyc_type;
  end

  // Status the next cycle will show; the code is shown in T1 and T2, passive from T3
  wire starting = (next_ts == lbc_pkg::T_1);
  wire in_cycle = (next_ts == lbc_pkg::T_1) || (next_ts == lbc_pkg::T_2);
  wire [2:0] next_status = starting ? cyc_type : (in_cycle ? cur_type : lbc_pkg::ST_PASSIVE); // [R1] [R2] [R3]
  wire next_hold = (next_ts == lbc_pkg::T_HOLD);
  wire is_write = (cur_type == lbc_pkg::ST_MWR) || (cur_type == lbc_pkg::ST_IOWR);
  wire is_int_ack_strobe_n = (cur_type == lbc_pkg::ST_INT_ACK_STROBE_N);
  wire is_xfer = (cur_type != lbc_pkg::ST_HALT) && (cur_type != lbc_pkg::ST_PASSIVE);
  wire data_phase = (next_ts == lbc_pkg::T_2) || (next_ts == lbc_pkg::T_3) ||
                    (next_ts == lbc_pkg::T_W) || (next_ts == lbc_pkg::T_4);
  wire next_type_sel = starting ? cyc_type[2] : cur_type[2];
  wire next_dir_sel = starting ? cyc_type[1] : cur_type[1];

  // Lock held from the prefix until the next instruction completes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) lock_act <= 1'b0;
    else if (lock_prefix) lock_act <= 1'b1; // [R10]
    else if (instr_done) lock_act <= 1'b0;
  end

  // Max mode outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus_status <= lbc_pkg::RST_STATUS;
      bus_status_oe <= 1'b0;
      lock_n <= 1'b1;
      lock_oe <= 1'b0;
      queue_state_bit1 <= lbc_pkg::RST_QUEUE[1];
      queue_state_bit0 <= lbc_pkg::RST_QUEUE[0];
    end else begin
      bus_status <= next_status;
      bus_status_oe <= !min_mode && !next_hold;
      lock_n <= !(lock_act || lock_prefix);
      lock_oe <= !min_mode && !next_hold; // [R10]
      queue_state_bit1 <= min_mode ? 1'b0 : queue_op[1]; // [R11]
      queue_state_bit0 <= min_mode ? 1'b0 : queue_op[0];
    end
  end

  // Grant lines only drive in max mode
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus_req_grant_hi_pri_out <= 1'b1;
      bus_req_grant_hi_pri_oe <= 1'b0;
      bus_req_grant_lo_pri_out <= 1'b1;
      bus_req_grant_lo_pri_oe <= 1'b0;
    end else begin
      bus_req_grant_hi_pri_out <= rg_hi_out;
      bus_req_grant_hi_pri_oe <= rg_hi_oe && !min_mode; // [R22]
      bus_req_grant_lo_pri_out <= rg_lo_out;
      bus_req_grant_lo_pri_oe <= rg_lo_oe && !min_mode;
    end
  end

  // Min mode controls; between cycles they stay driven and inactive
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mem_io_sel <= 1'b0;
      write_n <= 1'b1;
      int_ack_strobe_n <= 1'b1;
      addr_latch <= 1'b0;
      xcvr_direction <= 1'b0;
      xcvr_enable_n <= 1'b1;
      ctrl_oe <= 1'b0;
      hold_grant <= 1'b0;
    end else begin
      mem_io_sel <= in_cycle || data_phase ? next_type_sel : 1'b0; // [R12]
      write_n <= !(min_mode && data_phase && is_write); // [R13] [R23]
      int_ack_strobe_n <= !(min_mode && data_phase && is_int_ack_strobe_n); // [R14]
      addr_latch <= min_mode && starting; // [R15]
      xcvr_direction <= in_cycle || data_phase ? next_dir_sel : 1'b0; // [R16]
      // Whole-clock approximation: reads open one state later than writes
      xcvr_enable_n <= !(min_mode && is_xfer && (is_write ? data_phase
                         : ((next_ts == lbc_pkg::T_3) || (next_ts == lbc_pkg::T_W) ||
                            (next_ts == lbc_pkg::T_4)))); // [R17]
      ctrl_oe <= min_mode && !next_hold; // [R18] [R19] [R23]
      hold_grant <= min_mode && next_hold; // [R18]
    end
  end

  // Core handshake
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cyc_busy <= 1'b0;
      cyc_done <= 1'b0;
    end else begin
      cyc_busy <= (next_ts != lbc_pkg::T_IDLE) && (next_ts != lbc_pkg::T_HOLD);
      cyc_done <= (ts == lbc_pkg::T_4);
    end
  end

  a_alp_pulse: assert property (@(posedge ref_clk) disable iff (!nrst) // [R15]
    addr_latch |=> !addr_latch) else $error("latch pulse longer than one clock");
  a_hold_float: assert property (@(posedge ref_clk) disable iff (!nrst) // [R18]
    hold_grant |-> !ctrl_oe && !bus_status_oe) else $error("outputs driven in hold");
  a_status_end: assert property (@(posedge ref_clk) disable iff (!nrst) // [R3]
    (ts == lbc_pkg::T_3 && ready) |=> bus_status == lbc_pkg::ST_PASSIVE) else $error("status not passive");
  a_write_strobe: assert property (@(posedge ref_clk) disable iff (!nrst) // [R13]
    !write_n |-> min_mode && ctrl_oe) else $error("write strobe while not driving");
  a_grant_width: assert property (@(posedge ref_clk) disable iff (!nrst) // [R7]
    bus_req_grant_hi_pri_oe |=> !bus_req_grant_hi_pri_oe) else $error("grant pulse too wide");
  a_grant_prio: assert property (@(posedge ref_clk) disable iff (!nrst) // [R5]
    !(bus_req_grant_hi_pri_oe && bus_req_grant_lo_pri_oe)) else $error("two grants at once");
  a_lock_float: assert property (@(posedge ref_clk) disable iff (!nrst) // [R10]
    (ts == lbc_pkg::T_HOLD) |-> !lock_oe) else $error("lock driven in hold");
  a_int_ack_strobe_n_strobe: assert property (@(posedge ref_clk) disable iff (!nrst) // [R14]
    !int_ack_strobe_n |-> write_n) else $error("ack and write strobes together");
endmodule

// ==== sim/rg_master_model.sv ====
// Model of another local bus master on one request/grant line
`timescale 1ns/1ps
module rg_master_model (
  // Clock
  input wire logic ref_clk,
  // Line level and command
  input wire logic line,
  input wire logic go,
  // Line drive and tenure status
  output logic pull_low,
  output logic owned,
  output int grants,
  output int errs,
  output realtime grant_t
);
  int n;
  initial begin
    pull_low = 1'b0;
    owned = 1'b0;
    grants = 0;
    errs = 0;
    grant_t = 0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        @(negedge ref_clk);
        pull_low = 1'b1;
        @(negedge ref_clk);
        pull_low = 1'b0;
        n = 0;
        // Line is looked at mid-cycle so the grant register has settled
        do begin
          @(negedge ref_clk);
          n++;
        end while (line !== 1'b0 && n < 300);
        if (line !== 1'b0) begin
          errs++;
        end else begin
          grant_t = $realtime;
          grants++;
          @(negedge ref_clk);
          if (line !== 1'b1) begin
            errs++;
          end
          owned = 1'b1;
          repeat (6) @(negedge ref_clk);
          pull_low = 1'b1;
          @(negedge ref_clk);
          pull_low = 1'b0;
          owned = 1'b0;
          @(negedge ref_clk);
        end
      end
    end
  end
endmodule

// ==== sim/cpu_local_bus_control_tb_top.sv ====
// Self-checking bench for the local bus control block
`timescale 1ns/1ps
module cpu_local_bus_control_tb_top;
  logic ref_clk, nrst, min_mode_strap, cyc_req, ready, lock_prefix, instr_done, hold_req, q_on;
  logic [2:0] cyc_type, bus_status, st;
  logic [1:0] queue_op, qprev;
  logic cyc_busy, cyc_done, bus_status_oe, lock_n, lock_oe, queue_state_bit1, queue_state_bit0;
  logic hi_out, hi_oe, lo_out, lo_oe, hi_pull, lo_pull, hi_own, lo_own, go_hi, go_lo, mio, dir, coe;
  logic mem_io_sel, write_n, int_ack_strobe_n, addr_latch, xcvr_direction, xcvr_enable_n, ctrl_oe, hold_grant;
  int seed = 54029;
  int failures = 0;
  int num_checks = 0;
  int nb, nwr, nia, nen, nal, hi_g, lo_g, hi_e, lo_e, n;
  realtime hi_t, lo_t;
  // Request lines are open drain with a pull-up
  wire rg_hi = !((hi_oe && !hi_out) || hi_pull);
  wire rg_lo = !((lo_oe && !lo_out) || lo_pull);
  cpu_local_bus_control uut (.ref_clk, .nrst, .min_mode_strap, .cyc_req, .cyc_type, .ready, .lock_prefix,
    .instr_done, .queue_op, .cyc_busy, .cyc_done, .bus_status, .bus_status_oe, .lock_n, .lock_oe,
    .queue_state_bit1, .queue_state_bit0, .bus_req_grant_hi_pri_in(rg_hi), .bus_req_grant_hi_pri_out(hi_out),
    .bus_req_grant_hi_pri_oe(hi_oe), .bus_req_grant_lo_pri_in(rg_lo), .bus_req_grant_lo_pri_out(lo_out),
    .bus_req_grant_lo_pri_oe(lo_oe), .mem_io_sel, .write_n, .int_ack_strobe_n, .addr_latch, .xcvr_direction,
    .xcvr_enable_n, .ctrl_oe, .hold_req, .hold_grant);
  rg_master_model p_hi (.ref_clk, .line(rg_hi), .go(go_hi), .pull_low(hi_pull), .owned(hi_own), .grants(hi_g),
    .errs(hi_e), .grant_t(hi_t));
  rg_master_model p_lo (.ref_clk, .line(rg_lo), .go(go_lo), .pull_low(lo_pull), .owned(lo_own), .grants(lo_g),
    .errs(lo_e), .grant_t(lo_t));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task fail(input string m);
    failures++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task chk_bit(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e) fail(m);
  endtask
  task chk_code(input logic [2:0] g, input logic [2:0] e, input string m);
    num_checks++;
    if (g !== e) fail(m);
  endtask
  task chk_count(input int g, input int e, input string m);
    num_checks++;
    if (g != e) fail(m);
  endtask
  task to_chk(input string m);
    if (n >= 300) begin
      fail(m);
      give_verdict();
    end
  endtask
  // Ready and queue traffic are random so wait states vary
  always @(negedge ref_clk) begin
    ready = ($random(seed) % 3) != 0;
    queue_op = 2'($random(seed));
  end
  always @(posedge ref_clk) begin
    if (q_on) chk_code({1'b0, queue_state_bit1, queue_state_bit0}, {1'b0, min_mode_strap ? 2'h0 : qprev}, "queue");
    qprev = queue_op;
    if (hi_own || lo_own) begin
      chk_bit(bus_status_oe, 1'b0, "status driven in hold");
      chk_bit(lock_oe, 1'b0, "lock driven in hold");
    end
    if (cyc_busy === 1'b1) begin
      if (nb == 0) begin
        st = bus_status;
        mio = mem_io_sel;
        dir = xcvr_direction;
        coe = ctrl_oe;
      end
      nb++;
      nwr += int'(write_n === 1'b0);
      nia += int'(int_ack_strobe_n === 1'b0);
      nen += int'(xcvr_enable_n === 1'b0);
      nal += int'(addr_latch === 1'b1);
    end
  end
  task do_reset(input logic m);
    q_on = 1'b0;
    nrst = 1'b0;
    min_mode_strap = m;
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    q_on = 1'b1;
  endtask
  task bus_cycle(input logic [2:0] t);
    logic wr, ia, rd;
    wr = (t == lbc_pkg::ST_IOWR) || (t == lbc_pkg::ST_MWR);
    ia = t == lbc_pkg::ST_INT_ACK_STROBE_N;
    rd = (t == lbc_pkg::ST_IORD) || (t == lbc_pkg::ST_MRD) || (t == lbc_pkg::ST_CODE);
    nb = 0;
    nwr = 0;
    nia = 0;
    nen = 0;
    nal = 0;
    @(negedge ref_clk);
    cyc_type = t;
    cyc_req = 1'b1;
    for (n = 0; cyc_busy !== 1'b1 && n < 300; n++) @(negedge ref_clk);
    to_chk("no cycle start");
    cyc_req = 1'b0;
    for (n = 0; cyc_done !== 1'b1 && n < 300; n++) @(negedge ref_clk);
    to_chk("no cycle end");
    if (min_mode_strap) begin
      chk_count(nwr, wr ? nb - 1 : 0, "write strobe");
      chk_count(nia, ia ? nb - 1 : 0, "ack strobe");
      chk_count(nen, wr ? nb - 1 : (rd || ia) ? nb - 2 : 0, "xcvr enable");
      chk_count(nal, 1, "latch pulse");
      chk_bit(coe, 1'b1, "controls not driven");
      if (t != lbc_pkg::ST_HALT) begin
        chk_bit(mio, t[2], "mem io select");
        chk_bit(dir, t[1], "xcvr direction");
      end
    end else begin
      chk_code(st, t, "status code");
      chk_code(bus_status, lbc_pkg::ST_PASSIVE, "not passive");
    end
  endtask
  initial begin
    {nrst, min_mode_strap, cyc_req, lock_prefix, instr_done, hold_req, go_hi, go_lo, q_on} = '0;
    cyc_type = 3'h7;
    ready = 1'b1;
    queue_op = 2'h0;
    qprev = 2'h0;
    do_reset(1'b0);
    for (int i = 0; i < 7; i++) bus_cycle(3'(i));
    $display("test max mode cycles done");
    @(negedge ref_clk);
    go_hi = 1'b1;
    go_lo = 1'b1;
    @(negedge ref_clk);
    go_hi = 1'b0;
    go_lo = 1'b0;
    for (n = 0; lo_g != 1 && n < 300; n++) @(negedge ref_clk);
    to_chk("no low line grant");
    chk_bit(hi_t < lo_t, 1'b1, "priority");
    chk_count(hi_e + lo_e, 0, "grant pulse");
    bus_cycle(lbc_pkg::ST_MWR);
    $display("test priority done");
    lock_prefix = 1'b1;
    @(negedge ref_clk);
    lock_prefix = 1'b0;
    go_hi = 1'b1;
    chk_bit(lock_n, 1'b0, "lock not set");
    @(negedge ref_clk);
    go_hi = 1'b0;
    repeat (30) @(negedge ref_clk);
    chk_count(hi_g, 1, "grant under lock");
    instr_done = 1'b1;
    @(negedge ref_clk);
    instr_done = 1'b0;
    for (n = 0; hi_g != 2 && n < 300; n++) @(negedge ref_clk);
    to_chk("no grant after lock");
    chk_bit(lock_n, 1'b1, "lock stuck");
    bus_cycle(lbc_pkg::ST_CODE);
    $display("test lock done");
    do_reset(1'b1);
    chk_bit(bus_status_oe, 1'b0, "status pins in min mode");
    for (int i = 0; i < 7; i++) bus_cycle(3'(i));
    go_hi = 1'b1;
    @(negedge ref_clk);
    go_hi = 1'b0;
    repeat (12) @(negedge ref_clk);
    chk_count(hi_g, 2, "grant in min mode");
    hold_req = 1'b1;
    for (n = 0; hold_grant !== 1'b1 && n < 300; n++) @(negedge ref_clk);
    to_chk("no hold grant");
    chk_bit(ctrl_oe, 1'b0, "controls driven in hold");
    cyc_type = lbc_pkg::ST_MRD;
    cyc_req = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk_bit(cyc_busy, 1'b0, "cycle ran in hold");
    cyc_req = 1'b0;
    hold_req = 1'b0;
    for (n = 0; hold_grant !== 1'b0 && n < 300; n++) @(negedge ref_clk);
    to_chk("hold grant stuck");
    bus_cycle(lbc_pkg::ST_MRD);
    $display("test hold done");
    give_verdict();
  end
endmodule
